// >>> rtl/smar_regs.v
// Purpose: bus slave with vendor, threshold and mode registers, bus off/on sensing
// Assumes: open-drain bus pins sampled by the 125 MHz core clock
// Notes: read word and write word without packet error code
`include "smar_defs.vh"

module smar_regs #(
    parameter TICK_CYCLES = `SMAR_TICK_CYC
) (
    input wire CLK_IN,
    input wire RST_N_IN,
    input wire BUS_CLOCK_PIN_IN,
    input wire BUS_DATA_PIN_IN,
    output wire BUS_DATA_PIN_OUT,
    output wire BUS_DATA_PIN_OE_OUT,
    input wire [15:0] CAP_THR_FLASH_IN,
    input wire [15:0] TIME_THR_FLASH_IN,
    input wire [15:0] END_DISCHARGE_LEVEL_IN,
    input wire [15:0] CHARGE_LEFT_VALUE_IN,
    input wire [15:0] MEAN_MINUTES_LEFT_IN,
    input wire CYCLE_COUNT_PULSE_IN,
    input wire FULL_CAPACITY_UPDATE_IN,
    input wire LEARN_DONE_IN,
    input wire SLEEP_IN,
    output reg BUS_OFF_OUT,
    output reg SEALED_OUT,
    output reg ALARM_SEND_OUT,
    output reg ALARM_CAP_FLAG_OUT,
    output reg ALARM_TIME_FLAG_OUT,
    output reg CHARGE_REQ_EN_OUT,
    output reg UNITS_POWER_OUT,
    output reg RECOMPUTE_OUT
);
    localparam ST_IDLE = 3'h0;
    localparam ST_RX = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_TX = 3'h3;
    localparam ST_ACKIN = 3'h4;

    function alarm_hit;
        input [15:0] value;
        input [15:0] thr;
        begin
            alarm_hit = (thr != 16'h0000) && (value < thr);
        end
    endfunction

    function mapped;
        input [7:0] cmd;
        begin
            mapped = (cmd == `SMAR_CMD_VENDOR) || (cmd == `SMAR_CMD_CAP_THR) ||
                (cmd == `SMAR_CMD_TIME_THR) || (cmd == `SMAR_CMD_MODE);
        end
    endfunction

    reg scl_m_reg, scl_s_reg, scl_d_reg;
    reg sda_m_reg, sda_s_reg, sda_d_reg;
    reg [2:0] st_reg;
    reg [1:0] idx_reg;
    reg [3:0] bit_reg;
    reg [7:0] shf_reg;
    reg [7:0] cmd_reg;
    reg [7:0] lo_reg;
    reg rw_reg;
    reg ack_got_reg;
    reg oe_reg;
    reg [15:0] rd_reg;
    reg [15:0] vendor_reg;
    reg [15:0] cap_thr_reg;
    reg [15:0] time_thr_reg;
    reg alarm_dis_reg, chg_dis_reg, units_reg, relearn_reg;
    reg [4:0] cyc_reg;
    reg init_done_reg;
    reg sleep_d_reg;
    reg [16:0] pre_reg;
    reg tick_reg;
    reg [11:0] off_cnt_reg;
    reg [15:0] hold_reg;
    reg [13:0] space_reg;

    wire scl_rise = scl_s_reg & ~scl_d_reg;
    wire scl_fall = ~scl_s_reg & scl_d_reg;
    wire start_ev = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg;
    wire stop_ev = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;
    wire byte_end = scl_fall && (st_reg == ST_RX) && (bit_reg == 4'h8);
    wire [15:0] wr_word = {shf_reg, lo_reg};
    wire wr_commit = byte_end && (idx_reg == 2'h3) && !rw_reg;
    wire mode_wr = wr_commit && (cmd_reg == `SMAR_CMD_MODE);
    wire sleep_entry = SLEEP_IN & ~sleep_d_reg;
    wire cap_hit = alarm_hit(CHARGE_LEFT_VALUE_IN, cap_thr_reg);
    wire time_hit = alarm_hit(MEAN_MINUTES_LEFT_IN, time_thr_reg);
    wire [15:0] mode_word = {units_reg, chg_dis_reg, alarm_dis_reg, 5'h00, relearn_reg, 7'h00};
    wire units_next = mode_wr ? wr_word[`SMAR_MODE_UNITS] : (sleep_entry ? 1'b0 : units_reg);

    assign BUS_DATA_PIN_OUT = 1'b0;
    assign BUS_DATA_PIN_OE_OUT = oe_reg;

    // pin synchronisers and edge history
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            scl_m_reg <= 1'b1;
            scl_s_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_m_reg <= BUS_CLOCK_PIN_IN;
            scl_s_reg <= scl_m_reg;
            scl_d_reg <= scl_s_reg;
            sda_m_reg <= BUS_DATA_PIN_IN;
            sda_s_reg <= sda_m_reg;
            sda_d_reg <= sda_s_reg;
        end
    end

    // millisecond tick and bus off sensing
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pre_reg <= 17'h00000;
            tick_reg <= 1'b0;
            off_cnt_reg <= 12'h000;
            BUS_OFF_OUT <= 1'b0;
        end else begin
            tick_reg <= (pre_reg == TICK_CYCLES - 1);
            pre_reg <= (pre_reg == TICK_CYCLES - 1) ? 17'h00000 : pre_reg + 17'h00001;
            if (scl_s_reg | sda_s_reg) begin
                off_cnt_reg <= 12'h000;
                BUS_OFF_OUT <= 1'b0;
            end else if (tick_reg && off_cnt_reg != `SMAR_BUSOFF_TICKS) begin
                off_cnt_reg <= off_cnt_reg + 12'h001;
            end else if (off_cnt_reg == `SMAR_BUSOFF_TICKS) begin
                BUS_OFF_OUT <= 1'b1;
            end
        end
    end

    // bus slave protocol engine
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_reg <= ST_IDLE;
            idx_reg <= 2'h0;
            bit_reg <= 4'h0;
            shf_reg <= 8'h00;
            cmd_reg <= 8'h00;
            lo_reg <= 8'h00;
            rw_reg <= 1'b0;
            ack_got_reg <= 1'b0;
            oe_reg <= 1'b0;
            rd_reg <= 16'h0000;
        end else if (start_ev) begin
            st_reg <= ST_RX;
            idx_reg <= 2'h0;
            bit_reg <= 4'h0;
            oe_reg <= 1'b0;
        end else if (stop_ev || BUS_OFF_OUT) begin
            st_reg <= ST_IDLE;
            oe_reg <= 1'b0;
        end else begin
            case (st_reg)
                ST_RX: begin
                    if (scl_rise && bit_reg != 4'h8) begin
                        shf_reg <= {shf_reg[6:0], sda_s_reg};
                        bit_reg <= bit_reg + 4'h1;
                    end else if (byte_end) begin
                        bit_reg <= 4'h0;
                        st_reg <= ST_ACK;
                        oe_reg <= 1'b1;
                        case (idx_reg)
                            2'h0: begin
                                if (shf_reg[7:1] != `SMAR_SLAVE_ADDR) begin
                                    st_reg <= ST_IDLE;
                                    oe_reg <= 1'b0;
                                end
                                rw_reg <= shf_reg[0];
                                case (cmd_reg)
                                    `SMAR_CMD_VENDOR: rd_reg <= vendor_reg;
                                    `SMAR_CMD_CAP_THR: rd_reg <= cap_thr_reg;
                                    `SMAR_CMD_TIME_THR: rd_reg <= time_thr_reg;
                                    default: rd_reg <= mode_word;
                                endcase
                            end
                            2'h1: begin
                                cmd_reg <= shf_reg;
                                if (!mapped(shf_reg)) begin
                                    st_reg <= ST_IDLE;
                                    oe_reg <= 1'b0;
                                end
                            end
                            2'h2: lo_reg <= shf_reg;
                            default: lo_reg <= lo_reg;
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg && idx_reg == 2'h0) begin
                            st_reg <= ST_TX;
                            idx_reg <= 2'h2;
                            shf_reg <= rd_reg[7:0];
                            oe_reg <= ~rd_reg[7];
                            bit_reg <= 4'h0;
                        end else begin
                            oe_reg <= 1'b0;
                            st_reg <= (idx_reg == 2'h3) ? ST_IDLE : ST_RX;
                            idx_reg <= idx_reg + 2'h1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_reg <= bit_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_reg == 4'h8) begin
                            oe_reg <= 1'b0;
                            st_reg <= ST_ACKIN;
                        end else begin
                            shf_reg <= {shf_reg[6:0], 1'b0};
                            oe_reg <= ~shf_reg[6];
                        end
                    end
                end
                ST_ACKIN: begin
                    if (scl_rise) begin
                        ack_got_reg <= ~sda_s_reg;
                    end else if (scl_fall) begin
                        if (ack_got_reg && idx_reg == 2'h2) begin
                            st_reg <= ST_TX;
                            idx_reg <= 2'h3;
                            shf_reg <= rd_reg[15:8];
                            oe_reg <= ~rd_reg[15];
                            bit_reg <= 4'h0;
                        end else begin
                            st_reg <= ST_IDLE;
                        end
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // register file and mode control
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            vendor_reg <= 16'h0000;
            cap_thr_reg <= 16'h0000;
            time_thr_reg <= 16'h0000;
            init_done_reg <= 1'b0;
            SEALED_OUT <= 1'b0;
            alarm_dis_reg <= 1'b0;
            chg_dis_reg <= 1'b0;
            units_reg <= 1'b0;
            relearn_reg <= 1'b1;
            cyc_reg <= 5'h00;
            sleep_d_reg <= 1'b0;
            hold_reg <= 16'h0000;
            RECOMPUTE_OUT <= 1'b0;
        end else begin
            sleep_d_reg <= SLEEP_IN;
            init_done_reg <= 1'b1;
            if (!init_done_reg) begin
                cap_thr_reg <= CAP_THR_FLASH_IN;
                time_thr_reg <= TIME_THR_FLASH_IN;
            end else if (wr_commit && cmd_reg == `SMAR_CMD_CAP_THR) begin
                cap_thr_reg <= wr_word;
            end else if (wr_commit && cmd_reg == `SMAR_CMD_TIME_THR) begin
                time_thr_reg <= wr_word;
            end
            if (wr_commit && cmd_reg == `SMAR_CMD_VENDOR) begin
                case (wr_word)
                    `SMAR_VC_PART_ID: vendor_reg <= `SMAR_PART_ID_VAL;
                    `SMAR_VC_FW_REV: vendor_reg <= `SMAR_FW_REV_VAL;
                    `SMAR_VC_EDV: vendor_reg <= END_DISCHARGE_LEVEL_IN;
                    `SMAR_VC_SEAL: begin
                        SEALED_OUT <= 1'b1;
                        vendor_reg <= 16'h0000;
                    end
                    default: vendor_reg <= wr_word;
                endcase
            end
            // bits 0-6, 8-12 have no storage at all
            if (mode_wr) begin
                alarm_dis_reg <= wr_word[`SMAR_MODE_ALARM_DIS];
                chg_dis_reg <= wr_word[`SMAR_MODE_CHG_DIS];
                hold_reg <= `SMAR_HOLD_MS;
            end else if (sleep_entry) begin
                alarm_dis_reg <= 1'b0;
                chg_dis_reg <= 1'b0;
            end else if (tick_reg && hold_reg != 16'h0000) begin
                hold_reg <= hold_reg - 16'h0001;
                if (hold_reg == 16'h0001) begin
                    alarm_dis_reg <= 1'b0;
                end
            end
            units_reg <= units_next;
            RECOMPUTE_OUT <= units_next ^ units_reg;
            if (FULL_CAPACITY_UPDATE_IN) begin
                cyc_reg <= 5'h00;
            end else if (CYCLE_COUNT_PULSE_IN && cyc_reg != `SMAR_RELEARN_CYCLES) begin
                cyc_reg <= cyc_reg + 5'h01;
            end
            if (cyc_reg == `SMAR_RELEARN_CYCLES) begin
                relearn_reg <= 1'b1;
            end else if (LEARN_DONE_IN) begin
                relearn_reg <= 1'b0;
            end
        end
    end

    // alarm broadcast scheduling
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            space_reg <= 14'h0000;
            ALARM_SEND_OUT <= 1'b0;
            ALARM_CAP_FLAG_OUT <= 1'b0;
            ALARM_TIME_FLAG_OUT <= 1'b0;
            CHARGE_REQ_EN_OUT <= 1'b0;
            UNITS_POWER_OUT <= 1'b0;
        end else begin
            CHARGE_REQ_EN_OUT <= ~chg_dis_reg;
            UNITS_POWER_OUT <= units_reg;
            ALARM_SEND_OUT <= 1'b0;
            if (space_reg != 14'h0000) begin
                if (tick_reg) begin
                    space_reg <= space_reg - 14'h0001;
                end
            end else if ((cap_hit | time_hit) && !alarm_dis_reg) begin
                ALARM_SEND_OUT <= 1'b1;
                ALARM_CAP_FLAG_OUT <= cap_hit;
                ALARM_TIME_FLAG_OUT <= time_hit;
                space_reg <= `SMAR_SPACE_TICKS;
            end
        end
    end
endmodule

// >>> rtl/smar_defs.vh
// Purpose: constants for the gauge mode and alarm register block
// Assumes: 125 MHz core clock, 8 ns period
// Notes: times in ms are counted on a 1 ms tick
`ifndef SMAR_DEFS_VH
`define SMAR_DEFS_VH
`define SMAR_CLK_PERIOD_NS 8
`define SMAR_TICK_NS 1000000
`define SMAR_TICK_CYC (`SMAR_TICK_NS / `SMAR_CLK_PERIOD_NS)
`define SMAR_BUSOFF_MS 2000
`define SMAR_BUSOFF_TICKS 12'h7D1
`define SMAR_BUSON_MS 1
`define SMAR_HOLD_MS 16'hEA60
`define SMAR_SPACE_MS 10000
`define SMAR_SPACE_TICKS 14'h2711
`define SMAR_RELEARN_CYCLES 5'h14
`define SMAR_SLAVE_ADDR 7'h0B
`define SMAR_CMD_VENDOR 8'h00
`define SMAR_CMD_CAP_THR 8'h01
`define SMAR_CMD_TIME_THR 8'h02
`define SMAR_CMD_MODE 8'h03
`define SMAR_VC_PART_ID 16'h0001
`define SMAR_VC_FW_REV 16'h0002
`define SMAR_VC_EDV 16'h0003
`define SMAR_VC_SEAL 16'h062B
`define SMAR_MODE_RELEARN 7
`define SMAR_MODE_CTRL_EN 8
`define SMAR_MODE_PRIMARY 9
`define SMAR_MODE_ALARM_DIS 13
`define SMAR_MODE_CHG_DIS 14
`define SMAR_MODE_UNITS 15
`define SMAR_PART_ID_VAL 16'h5A5A
`define SMAR_FW_REV_VAL 16'h0100
`endif

// >>> dv/smar_regs_props.sv
// Purpose: pin timing checks for the mode and alarm block
// Assumes: TICK_CYCLES matches the design instance
// Notes: bound into every smar_regs
module smar_regs_props #(
    parameter TICK_CYCLES = 125000
) (
    input wire CLK_IN,
    input wire RST_N_IN,
    input wire BUS_CLOCK_PIN_IN,
    input wire BUS_DATA_PIN_IN,
    input wire BUS_DATA_PIN_OUT,
    input wire BUS_DATA_PIN_OE_OUT,
    input wire SLEEP_IN,
    input wire BUS_OFF_OUT,
    input wire SEALED_OUT,
    input wire ALARM_SEND_OUT,
    input wire ALARM_CAP_FLAG_OUT,
    input wire ALARM_TIME_FLAG_OUT,
    input wire CHARGE_REQ_EN_OUT,
    input wire UNITS_POWER_OUT,
    input wire RECOMPUTE_OUT
);
    reg [31:0] low_reg;
    reg [31:0] gap_reg;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // cycles both lines low, cycles since last alarm
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            low_reg <= 32'h0;
            gap_reg <= 32'hFFFFFFFF;
        end else begin
            low_reg <= (BUS_CLOCK_PIN_IN || BUS_DATA_PIN_IN) ? 32'h0 : low_reg + 32'h1;
            gap_reg <= ALARM_SEND_OUT ? 32'h1 : ((&gap_reg) ? gap_reg : gap_reg + 32'h1);
        end
    end
    a_busoff_after_low: assert property ($rose(BUS_OFF_OUT) |-> low_reg >= 2000 * TICK_CYCLES)
        else $error("bus off declared too early");
    a_buson_quick: assert property (BUS_OFF_OUT && BUS_CLOCK_PIN_IN && BUS_DATA_PIN_IN |-> ##[1:8] !BUS_OFF_OUT)
        else $error("bus on not recognised");
    a_alarm_spacing: assert property (ALARM_SEND_OUT |-> gap_reg >= 10000 * TICK_CYCLES)
        else $error("alarms too close");
    a_alarm_has_flag: assert property (ALARM_SEND_OUT |-> ##[0:1] (ALARM_CAP_FLAG_OUT || ALARM_TIME_FLAG_OUT))
        else $error("alarm without flag");
    a_sleep_clears: assert property ($rose(SLEEP_IN) |-> ##[1:4] (CHARGE_REQ_EN_OUT && !UNITS_POWER_OUT))
        else $error("sleep left mode bits set");
    a_units_recompute: assert property ($changed(UNITS_POWER_OUT) |-> $past(RECOMPUTE_OUT))
        else $error("no recompute after units change");
    a_seal_sticks: assert property (SEALED_OUT |=> SEALED_OUT)
        else $error("seal dropped");
    a_oe_clock_low: assert property ($rose(BUS_DATA_PIN_OE_OUT) |-> !BUS_CLOCK_PIN_IN)
        else $error("data driven while clock high");
    a_open_drain: assert property (BUS_DATA_PIN_OE_OUT |-> !BUS_DATA_PIN_OUT)
        else $error("data pin driven high");
endmodule

bind smar_regs smar_regs_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.CLK_IN, .RST_N_IN, .BUS_CLOCK_PIN_IN,
    .BUS_DATA_PIN_IN, .BUS_DATA_PIN_OUT, .BUS_DATA_PIN_OE_OUT, .SLEEP_IN, .BUS_OFF_OUT, .SEALED_OUT,
    .ALARM_SEND_OUT, .ALARM_CAP_FLAG_OUT, .ALARM_TIME_FLAG_OUT, .CHARGE_REQ_EN_OUT, .UNITS_POWER_OUT,
    .RECOMPUTE_OUT);

// >>> dv/smar_host.sv
// Purpose: bus host model, read word and write word
// Assumes: open-drain lines with pull-ups, 125 ns bit time
// Notes: 1 on scl_out or 0 on sda_low_out releases a line
module smar_host (
    output logic scl_out,
    output logic sda_low_out,
    input wire logic sda_in
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic lines(input logic lvl);
        scl_out = lvl;
        sda_low_out = !lvl;
    endtask
    // start or repeated start
    task automatic start_c;
        sda_low_out = 1'b0;
        #HALF scl_out = 1'b1;
        #HALF sda_low_out = 1'b1;
        #HALF scl_out = 1'b0;
    endtask
    task automatic stop_c;
        sda_low_out = 1'b1;
        #HALF scl_out = 1'b1;
        #HALF sda_low_out = 1'b0;
        #HALF;
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_low_out = !b;
        #HALF scl_out = 1'b1;
        #HALF r = sda_in;
        scl_out = 1'b0;
    endtask
    // msb first, ninth bit is ack slot
    task automatic xbyte(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) xbit(tx[i], rx[i]);
        xbit(last, ack);
        ack = !ack;
    endtask
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] d);
        logic [7:0] rx;
        logic a;
        start_c();
        xbyte({7'h0B, 1'b0}, 1'b1, rx, a);
        xbyte(cmd, 1'b1, rx, a);
        xbyte(d[7:0], 1'b1, rx, a);
        xbyte(d[15:8], 1'b1, rx, a);
        stop_c();
    endtask
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic ack);
        logic a0;
        logic a1;
        logic x;
        d = 16'h0;
        start_c();
        xbyte({7'h0B, 1'b0}, 1'b1, d[7:0], a0);
        xbyte(cmd, 1'b1, d[7:0], a1);
        ack = a0 && a1;
        if (!ack) begin
            stop_c();
            return;
        end
        start_c();
        xbyte({7'h0B, 1'b1}, 1'b1, d[7:0], ack);
        xbyte(8'hFF, 1'b0, d[7:0], x);
        xbyte(8'hFF, 1'b1, d[15:8], x);
        stop_c();
    endtask
endmodule

// >>> dv/tb_top.sv
// Purpose: register and alarm tests for smar_regs
// Assumes: one ms tick per core clock for short runs
// Notes: host model drives the bus pins
`include "smar_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] chg_left = 16'hFFFF;
    logic [15:0] minutes = 16'hFFFF;
    logic cyc = 1'b0;
    logic fcc_upd = 1'b0;
    logic learn_done = 1'b0;
    logic sleep = 1'b0;
    logic [15:0] cap_flash = 16'h0100;
    logic [15:0] time_flash = 16'h0005;
    logic [15:0] end_discharge_level = 16'h0777;
    logic recomp;
    int recomp_cnt = 0;
    logic [15:0] qv [1:3] = '{`SMAR_PART_ID_VAL, `SMAR_FW_REV_VAL, 16'h0777};
    logic h_scl, h_low, d_out, oe, bus_off, sealed, send, cap_f, time_f, chg_en, units;
    int fail_count = 0;
    int num_checks = 0;
    int alarm_cnt = 0;
    int cyc_cnt = 0;
    wire sda = !(h_low || (oe && !d_out));
    initial forever #4 clk_in = ~clk_in;
    smar_host u_host (.scl_out(h_scl), .sda_low_out(h_low), .sda_in(sda));
    smar_regs #(.TICK_CYCLES(1)) uut (.CLK_IN(clk_in), .RST_N_IN(rst_n_in), .BUS_CLOCK_PIN_IN(h_scl),
        .BUS_DATA_PIN_IN(sda), .BUS_DATA_PIN_OUT(d_out), .BUS_DATA_PIN_OE_OUT(oe), .CAP_THR_FLASH_IN(cap_flash),
        .TIME_THR_FLASH_IN(time_flash), .END_DISCHARGE_LEVEL_IN(end_discharge_level), .CHARGE_LEFT_VALUE_IN(chg_left),
        .MEAN_MINUTES_LEFT_IN(minutes), .CYCLE_COUNT_PULSE_IN(cyc), .FULL_CAPACITY_UPDATE_IN(fcc_upd),
        .LEARN_DONE_IN(learn_done), .SLEEP_IN(sleep), .BUS_OFF_OUT(bus_off), .SEALED_OUT(sealed),
        .ALARM_SEND_OUT(send), .ALARM_CAP_FLAG_OUT(cap_f), .ALARM_TIME_FLAG_OUT(time_f),
        .CHARGE_REQ_EN_OUT(chg_en), .UNITS_POWER_OUT(units), .RECOMPUTE_OUT(recomp));
    task automatic end_sim;
        if (fail_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] d;
        logic a;
        u_host.read_word(cmd, d, a);
        check(d, exp);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_in) cyc <= 1'b1;
            @(posedge clk_in) cyc <= 1'b0;
        end
    endtask
    task automatic wait_alarm(input int lim, input logic [15:0] flags);
        int n;
        n = alarm_cnt;
        repeat (lim) if (alarm_cnt == n) @(posedge clk_in);
        check(16'(alarm_cnt - n), 16'h1);
        check({14'h0, cap_f, time_f}, flags);
    endtask
    always @(posedge clk_in) begin
        cyc_cnt <= cyc_cnt + 1;
        if (send) alarm_cnt <= alarm_cnt + 1;
        if (recomp) recomp_cnt <= recomp_cnt + 1;
        if (cyc_cnt == 98000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        logic [15:0] d;
        logic a;
        cycles(20);
        rst_n_in <= 1'b1;
        cycles(8);
        cap_flash <= 16'h0200;
        time_flash <= 16'h0009;
        rd(8'h01, 16'h0100);
        rd(8'h02, 16'h0005);
        rd(8'h03, 16'h0080);
        for (int i = 1; i < 4; i++) begin
            u_host.write_word(8'h00, i[15:0]);
            rd(8'h00, qv[i]);
        end
        u_host.write_word(8'h00, 16'h062B);
        rd(8'h00, 16'h0000);
        check({15'h0, sealed}, 16'h1);
        @(posedge clk_in) learn_done <= 1'b1;
        @(posedge clk_in) learn_done <= 1'b0;
        rd(8'h03, 16'h0000);
        pulses(10);
        @(posedge clk_in) fcc_upd <= 1'b1;
        @(posedge clk_in) fcc_upd <= 1'b0;
        pulses(19);
        rd(8'h03, 16'h0000);
        pulses(1);
        rd(8'h03, 16'h0080);
        u_host.write_word(8'h03, 16'hFFFF);
        rd(8'h03, 16'hE080);
        check({14'h0, units, chg_en}, 16'h2);
        check(16'(recomp_cnt), 16'h1);
        @(posedge clk_in) chg_left <= 16'h0010;
        a = 1'b0;
        cycles(57000); // no rewrite of the disable bit
        check(16'(alarm_cnt), 16'h0);
        wait_alarm(4000, 16'h2);
        u_host.write_word(8'h01, 16'h0000);
        u_host.write_word(8'h02, 16'h0020);
        rd(8'h02, 16'h0020);
        @(posedge clk_in) minutes <= 16'h0010;
        wait_alarm(11000, 16'h1);
        u_host.write_word(8'h03, 16'hE000);
        @(posedge clk_in) sleep <= 1'b1;
        cycles(4);
        check({14'h0, units, chg_en}, 16'h1);
        check(16'(recomp_cnt), 16'h2);
        @(posedge clk_in) sleep <= 1'b0;
        rd(8'h03, 16'h0080);
        u_host.lines(1'b0);
        cycles(1900);
        check({15'h0, bus_off}, 16'h0);
        cycles(300);
        check({15'h0, bus_off}, 16'h1);
        u_host.lines(1'b1);
        cycles(20);
        check({15'h0, bus_off}, 16'h0);
        rd(8'h01, 16'h0000);
        u_host.read_word(8'h04, d, a);
        check({15'h0, a}, 16'h0);
        end_sim();
    end
endmodule
